// >>> hw/frtc_top.sv
// Free-running 16-bit timer counter with a Wishbone register slave
//
// What this block does
// RULE1: 16-bit free counter, high and low bytes
// RULE2: Clock from CPU/2, /4, /8 or pin
// RULE3: Writing either low byte reloads FFFCh
// RULE4: Reset value FFFCh, the only reload value
// RULE5: Alternate view; its low read keeps flag
// RULE6: High read first captures the low byte
// RULE7: Captured byte holds until low byte read
// RULE8: Lone low read returns live low byte
// RULE9: Wrap FFFFh to 0000h sets overflow flag
// RULE10: Interrupt when enabled and CPU unmasked
// RULE11: Clear flag: status read, main low access
// RULE12: Counter keeps running in wait mode
// RULE13: Halt freezes count; resume held value
// RULE14: Edge select picks rising or falling
// RULE15: Counter updates synchronous to CPU clock
// RULE16: External edges at least four clocks apart
// RULE17: Unbonded timer pin reads as one
// RULE18: Instances share nothing, stay aligned
// RULE19: Count steps by one and wraps
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "frtc_regs.svh"
module frtc_top
  import frtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic extCountPin,
  input wire logic extPinBonded,
  input wire logic haltMode,
  input wire logic cpuIrqMask,
  output logic timerIrq,
  output logic irq
);

  frtc_count_t counter;
  frtc_byte_t holdLow;
  frtc_byte_t liveOrHeld;
  frtc_seq_e seqState;
  logic overflowFlag;
  logic statusArmed;
  logic ovfIrqEnable;
  logic [1:0] clockSelect;
  logic extEdgeSelect;
  logic tick;
  logic countEn;
  logic wrap;
  logic busAcc;
  logic rdEn;
  logic wrEn;
  logic hitCntHi;
  logic hitCntLo;
  logic hitAltHi;
  logic hitAltLo;
  logic hitStatus;
  logic hitCtrl1;
  logic hitCtrl2;
  logic hitIrqStat;
  logic hitIrqClr;
  logic hitIrqEn;
  logic rdHigh;
  logic rdLow;
  logic reload;
  logic mainLowAcc;
  logic rdStatus;
  logic flagClear;
  logic [1:0] irqStatus;
  logic [1:0] irqEnable;
  logic [1:0] irqEvents;
  logic [31:0] next_rdData;

  // Bus access is taken in the cycle before ack; ack lasts one cycle
  assign busAcc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rdEn = busAcc & ~wb_we_i;
  assign wrEn = busAcc & wb_we_i & wb_sel_i[0];

  // Register decode
  assign hitCntHi = frtc_hit(wb_adr_i, `FRTC_ADR_CNT_HI);
  assign hitCntLo = frtc_hit(wb_adr_i, `FRTC_ADR_CNT_LO);
  assign hitAltHi = frtc_hit(wb_adr_i, `FRTC_ADR_ALT_HI);
  assign hitAltLo = frtc_hit(wb_adr_i, `FRTC_ADR_ALT_LO);
  assign hitStatus = frtc_hit(wb_adr_i, `FRTC_ADR_STATUS);
  assign hitCtrl1 = frtc_hit(wb_adr_i, `FRTC_ADR_CTRL1);
  assign hitCtrl2 = frtc_hit(wb_adr_i, `FRTC_ADR_CTRL2);
  assign hitIrqStat = frtc_hit(wb_adr_i, `FRTC_ADR_IRQ_STAT);
  assign hitIrqClr = frtc_hit(wb_adr_i, `FRTC_ADR_IRQ_CLR);
  assign hitIrqEn = frtc_hit(wb_adr_i, `FRTC_ADR_IRQ_EN);

  // Access events with side effects
  assign rdHigh = rdEn & (hitCntHi | hitAltHi);
  assign rdLow = rdEn & (hitCntLo | hitAltLo);
  assign rdStatus = rdEn & hitStatus;
  assign reload = wrEn & (hitCntLo | hitAltLo); // RULE3
  // Any read or write of the main low byte, never the alternate
  assign mainLowAcc = busAcc & hitCntLo; // RULE5 RULE11

  // Tick source: prescaler or qualified pin edge
  frtc_tick u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .clockSelect(clockSelect),
    .extEdgeSelect(extEdgeSelect),
    .extCountPin(extCountPin),
    .extPinBonded(extPinBonded),
    .tick(tick)
  );

  // Halt freezes the count; wait mode has no input here on purpose,
  // so the counter simply keeps running through it
  assign countEn = tick & ~haltMode; // RULE12 RULE13
  assign wrap = countEn & ~reload & (counter == `FRTC_CNT_MAX); // RULE9

  // Counter; the single clock edge stands in for the falling CPU edge
  always_ff @(posedge clk_sys or posedge rst) begin // RULE15
    if (rst) begin
      counter <= `FRTC_RELOAD; // RULE4
    end else if (reload) begin
      counter <= `FRTC_RELOAD; // RULE3
    end else if (countEn) begin
      counter <= counter + `FRTC_CNT_ONE; // RULE1 RULE19
    end
  end

  // Coherent 16-bit read: a high read captures the low byte once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seqState <= SEQ_IDLE;
      holdLow <= `FRTC_BYTE_ZERO;
    end else begin
      unique case (seqState)
        SEQ_IDLE: begin
          if (rdHigh) begin
            holdLow <= counter[`FRTC_LOW_BYTE]; // RULE6
            seqState <= SEQ_HELD;
          end
        end
        SEQ_HELD: begin
          // Repeated high reads leave the captured byte alone
          if (rdLow) begin
            seqState <= SEQ_IDLE; // RULE7
          end
        end
        default: begin
          seqState <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Held byte inside a sequence, live byte otherwise
  assign liveOrHeld = (seqState == SEQ_HELD) ? holdLow :
                      counter[`FRTC_LOW_BYTE]; // RULE7 RULE8

  // First clearing step: status read while the flag is set
  always_ff @(posedge clk_sys or posedge rst) begin // RULE11
    if (rst) begin
      statusArmed <= 1'b0;
    end else if (rdStatus & overflowFlag) begin
      statusArmed <= 1'b1;
    end else if (mainLowAcc) begin
      statusArmed <= 1'b0;
    end
  end

  assign flagClear = statusArmed & mainLowAcc; // RULE11

  // Overflow flag; a wrap in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      overflowFlag <= 1'b0;
    end else if (wrap) begin
      overflowFlag <= 1'b1; // RULE9
    end else if (flagClear) begin
      overflowFlag <= 1'b0; // RULE11
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovfIrqEnable <= `FRTC_CR1_RST;
      clockSelect <= `FRTC_CR2_CS_RST;
      extEdgeSelect <= `FRTC_CR2_EDGE_RST;
    end else if (wrEn & hitCtrl1) begin
      ovfIrqEnable <= wb_dat_i[`FRTC_CR1_OVIE];
    end else if (wrEn & hitCtrl2) begin
      clockSelect <= wb_dat_i[`FRTC_CR2_CS]; // RULE2
      extEdgeSelect <= wb_dat_i[`FRTC_CR2_EDGE]; // RULE14
    end
  end

  // Timer request stays pending until enable and CPU mask allow it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      timerIrq <= 1'b0;
    end else begin
      timerIrq <= overflowFlag & ovfIrqEnable & ~cpuIrqMask; // RULE10
    end
  end

  // Sticky events: wrap and software reload
  always_comb begin
    irqEvents = `FRTC_IRQ_RST;
    irqEvents[`FRTC_IRQ_OVF] = wrap;
    irqEvents[`FRTC_IRQ_RLD] = reload;
  end

  frtc_irq u_irq (
    .clk_sys(clk_sys),
    .rst(rst),
    .eventIn(irqEvents),
    .clearWr(wrEn & hitIrqClr),
    .enableWr(wrEn & hitIrqEn),
    .wrData(wb_dat_i[`FRTC_IRQ_N-1:0]),
    .irqStatus(irqStatus),
    .irqEnable(irqEnable),
    .irq(irq)
  );

  // Read mux; unmapped and write-only addresses read as zero
  always_comb begin
    next_rdData = `FRTC_WORD_ZERO;
    if (hitCntHi | hitAltHi) begin
      next_rdData[`FRTC_LOW_BYTE] = counter[`FRTC_HIGH_BYTE]; // RULE1
    end else if (hitCntLo | hitAltLo) begin
      next_rdData[`FRTC_LOW_BYTE] = liveOrHeld; // RULE5 RULE8
    end else if (hitStatus) begin
      next_rdData[`FRTC_SR_OVF] = overflowFlag;
    end else if (hitCtrl1) begin
      next_rdData[`FRTC_CR1_OVIE] = ovfIrqEnable;
    end else if (hitCtrl2) begin
      next_rdData[`FRTC_CR2_CS] = clockSelect;
      next_rdData[`FRTC_CR2_EDGE] = extEdgeSelect;
    end else if (hitIrqStat) begin
      next_rdData[`FRTC_IRQ_N-1:0] = irqStatus;
    end else if (hitIrqEn) begin
      next_rdData[`FRTC_IRQ_N-1:0] = irqEnable;
    end
  end

  // Ack and read data, both registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `FRTC_WORD_ZERO;
    end else begin
      wb_ack_o <= busAcc;
      if (rdEn) begin
        wb_dat_o <= next_rdData;
      end
    end
  end

  // Checks on the counter, flag and bus timing
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_statusArm;
    rdStatus && overflowFlag && !mainLowAcc;
  endsequence

  // Second step only counts while the first step is still armed
  sequence s_lowClear;
    statusArmed && mainLowAcc && !wrap;
  endsequence

  property p_reload;
    reload |=> counter == `FRTC_RELOAD;
  endproperty
  a_reload: assert property (p_reload) // RULE3
    else $error("low byte write did not reload the counter");

  property p_wrap;
    wrap |=> overflowFlag && counter == `FRTC_CNT_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) // RULE9
    else $error("wrap did not set overflow flag");

  property p_step;
    countEn && !reload && counter != `FRTC_CNT_MAX
      |=> counter == $past(counter) + `FRTC_CNT_ONE;
  endproperty
  a_step: assert property (p_step) // RULE19
    else $error("counter did not step by one");

  property p_halt;
    haltMode && !reload |=> $stable(counter);
  endproperty
  a_halt: assert property (p_halt) // RULE13
    else $error("counter moved in halt mode");

  property p_timer_irq;
    overflowFlag && ovfIrqEnable && !cpuIrqMask ##1
      overflowFlag && ovfIrqEnable && !cpuIrqMask |-> timerIrq;
  endproperty
  a_timer_irq: assert property (p_timer_irq) // RULE10
    else $error("pending timer request not raised");

  property p_alt_keeps;
    rdEn && hitAltLo && overflowFlag |=> overflowFlag;
  endproperty
  a_alt_keeps: assert property (p_alt_keeps) // RULE5
    else $error("alternate low read cleared the flag");

  property p_arm;
    s_statusArm |=> statusArmed;
  endproperty
  a_arm: assert property (p_arm) // RULE11
    else $error("status read did not arm the flag clear");

  // Bus turnaround puts a few cycles between the two steps
  property p_two_step;
    s_statusArm ##[1:8] s_lowClear |=> !overflowFlag;
  endproperty
  a_two_step: assert property (p_two_step) // RULE11
    else $error("two-step clear failed");

  property p_capture;
    rdHigh && seqState == SEQ_IDLE
      |=> seqState == SEQ_HELD &&
          holdLow == $past(counter[`FRTC_LOW_BYTE]);
  endproperty
  a_capture: assert property (p_capture) // RULE6
    else $error("high read did not capture low byte");

  property p_hold;
    seqState == SEQ_HELD && !rdLow |=> $stable(holdLow);
  endproperty
  a_hold: assert property (p_hold) // RULE7
    else $error("captured low byte changed in sequence");

  property p_ack;
    busAcc |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a single cycle after request");

endmodule

// >>> hw/frtc_regs.svh
// Register offsets, field positions and reset values of the timer counter
`ifndef FRTC_REGS_SVH
`define FRTC_REGS_SVH

// Byte addresses on the Wishbone bus, one 32-bit word per register
`define FRTC_ADR_CNT_HI 8'h00
`define FRTC_ADR_CNT_LO 8'h04
`define FRTC_ADR_ALT_HI 8'h08
`define FRTC_ADR_ALT_LO 8'h0C
`define FRTC_ADR_STATUS 8'h10
`define FRTC_ADR_CTRL1 8'h14
`define FRTC_ADR_CTRL2 8'h18
`define FRTC_ADR_IRQ_STAT 8'h1C
`define FRTC_ADR_IRQ_CLR 8'h20
`define FRTC_ADR_IRQ_EN 8'h24

// Counter values
`define FRTC_RELOAD 16'hFFFC
`define FRTC_CNT_MAX 16'hFFFF
`define FRTC_CNT_ONE 16'h0001
`define FRTC_CNT_ZERO 16'h0000

// Field positions
`define FRTC_LOW_BYTE 7:0
`define FRTC_HIGH_BYTE 15:8
`define FRTC_SR_OVF 7
`define FRTC_CR1_OVIE 7
`define FRTC_CR2_CS 1:0
`define FRTC_CR2_EDGE 2
`define FRTC_IRQ_OVF 0
`define FRTC_IRQ_RLD 1
`define FRTC_IRQ_N 2

// Reset values
`define FRTC_CR1_RST 1'h0
`define FRTC_CR2_CS_RST 2'h0
`define FRTC_CR2_EDGE_RST 1'h0
`define FRTC_IRQ_RST 2'h0
`define FRTC_BYTE_ZERO 8'h00
`define FRTC_WORD_ZERO 32'h00000000

// Clock select codes and prescaler masks
`define FRTC_CS_DIV2 2'h0
`define FRTC_CS_DIV4 2'h1
`define FRTC_CS_DIV8 2'h2
`define FRTC_CS_EXT 2'h3
`define FRTC_PRE_ZERO 3'h0
`define FRTC_PRE_ONE 3'h1
`define FRTC_PRE_MASK2 3'h1
`define FRTC_PRE_MASK4 3'h3
`define FRTC_PRE_MASK8 3'h7

`endif

// >>> hw/frtc_pkg.sv
// Types and helper functions shared by the timer counter modules
package frtc_pkg;

  // Coherent read sequence state, one-hot
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_HELD = 2'b10
  } frtc_seq_e;

  typedef logic [15:0] frtc_count_t;
  typedef logic [7:0] frtc_byte_t;

  // Register select from the bus byte address
  function automatic logic frtc_hit(input logic [7:0] adr,
                                    input logic [7:0] off);
    return adr == off;
  endfunction

endpackage

// >>> hw/frtc_tick.sv
// Prescaler and external clock pin qualifier producing count ticks
`timescale 1ns/100ps
`include "frtc_regs.svh"
module frtc_tick
  import frtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] clockSelect,
  input wire logic extEdgeSelect,
  input wire logic extCountPin,
  input wire logic extPinBonded,
  output logic tick
);

  logic [2:0] preCount;
  logic pinLevel;
  logic sync1;
  logic sync2;
  logic sync3;
  logic pinStable;
  logic extEdge;
  logic [2:0] preMask;

  // Free prescaler from reset; never cleared so that two instances
  // stay count-aligned while neither changes its clock select
  always_ff @(posedge clk_sys or posedge rst) begin // RULE18
    if (rst) begin
      preCount <= `FRTC_PRE_ZERO;
    end else begin
      preCount <= preCount + `FRTC_PRE_ONE;
    end
  end

  // A pin that is not bonded out reads as one
  assign pinLevel = extPinBonded ? extCountPin : 1'b1; // RULE17

  // Three-stage synchroniser; change accepted when stages 2 and 3 agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      pinStable <= 1'b1;
    end else begin
      sync1 <= pinLevel;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        pinStable <= sync3;
      end
    end
  end

  // Edge select: one counts rising, zero counts falling transitions
  // Sources faster than a quarter of the clock may lose edges here
  assign extEdge = (sync2 == sync3) && (sync3 != pinStable) &&
                   (sync3 == extEdgeSelect); // RULE14 RULE16

  // Division ratio by clock select
  always_comb begin // RULE2
    unique case (clockSelect)
      `FRTC_CS_DIV2: preMask = `FRTC_PRE_MASK2;
      `FRTC_CS_DIV4: preMask = `FRTC_PRE_MASK4;
      default: preMask = `FRTC_PRE_MASK8;
    endcase
  end

  assign tick = (clockSelect == `FRTC_CS_EXT) ? extEdge :
                ((preCount & preMask) == preMask); // RULE2

endmodule

// >>> hw/frtc_irq.sv
// Sticky event status with enable and write-one-to-clear
`timescale 1ns/100ps
`include "frtc_regs.svh"
module frtc_irq
  import frtc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] eventIn,
  input wire logic clearWr,
  input wire logic enableWr,
  input wire logic [1:0] wrData,
  output logic [1:0] irqStatus,
  output logic [1:0] irqEnable,
  output logic irq
);

  // A new event in the clearing cycle survives: set wins
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqStatus <= `FRTC_IRQ_RST;
    end else begin
      irqStatus <= (irqStatus & ~(clearWr ? wrData : `FRTC_IRQ_RST))
                   | eventIn;
    end
  end

  // Enable register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqEnable <= `FRTC_IRQ_RST;
    end else if (enableWr) begin
      irqEnable <= wrData;
    end
  end

  assign irq = |(irqStatus & irqEnable);

endmodule

// >>> verif/frtc_ext_src.sv
// External count clock source that drives the timer count pin
`timescale 1ns/100ps
module frtc_ext_src (
  input wire logic clk_sys,
  output logic pin
);
  // Pin starts low so the first toggle is a rising edge
  initial pin = 1'b0;

  // Edges six clocks apart, safely above the four-clock minimum
  task automatic toggle(input int n);
    repeat (n) begin
      repeat (6) @(posedge clk_sys);
      pin <= ~pin;
    end
    // Let the synchroniser settle before anyone samples the count
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

// >>> verif/test_free_running_timer_counter.sv
// Self-checking bench for the free-running timer counter
`timescale 1ns/100ps
`include "frtc_regs.svh"
module test_free_running_timer_counter;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic ack, extCountPin, timerIrq, irq;
  logic bonded = 1'b1;
  logic halt = 1'b1;
  logic mask = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  int mc;

  // 10 MHz system clock
  always #50 clk_sys = ~clk_sys;

  frtc_top i_frtc_top (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .extCountPin(extCountPin),
    .extPinBonded(bonded), .haltMode(halt), .cpuIrqMask(mask),
    .timerIrq(timerIrq), .irq(irq)
  );

  frtc_ext_src i_frtc_ext_src (.clk_sys(clk_sys), .pin(extCountPin));

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = rdat;
    check("ack", 16'(n < 100), 16'h0001);
    cyc <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h00000000, q);
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [15:0] e);
    logic [31:0] q;
    rd(a, q);
    check(nm, q[15:0], e);
  endtask

  // Coherent word read, high byte first
  task automatic rdw(input logic [7:0] a, output logic [15:0] w);
    logic [31:0] h;
    logic [31:0] l;
    rd(a, h);
    rd(a + 8'h04, l);
    w = {h[7:0], l[7:0]};
  endtask

  // Any data value reloads, so random data is sent
  task automatic reload();
    wr(`FRTC_ADR_CNT_LO, $urandom);
    mc = 'hFFFC;
  endtask

  // Main sequence; prescaled counts are read with the counter halted, pin counts while it runs
  initial begin
    logic [15:0] w;
    logic [31:0] q;
    int p, k, pl;
    pl = 0;
    void'($urandom(81793));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdw(`FRTC_ADR_CNT_HI, w);
    check("reset count", w, 16'hFFFC);
    rc("status", `FRTC_ADR_STATUS, 16'h0000);
    rc("unmapped", 8'h30, 16'h0000);
    // Every prescaler, 64 clocks of running, wraps past FFFFh
    for (int cs = 0; cs < 3; cs++) begin
      wr(`FRTC_ADR_CTRL2, 32'(cs));
      reload();
      halt <= 1'b0;
      repeat (64) @(posedge clk_sys);
      halt <= 1'b1;
      @(posedge clk_sys);
      rdw(`FRTC_ADR_CNT_HI, w);
      p = 64 >> (cs + 1);
      k = int'(w + 16'h0004);
      check("ticks", 16'(k >= p - 1 && k <= p + 1), 16'h0001);
      rc("status", `FRTC_ADR_STATUS, 16'h0080);
    end
    // Sticky status, enable and clear of the level interrupt
    rc("irq status", `FRTC_ADR_IRQ_STAT, 16'h0003);
    wr(`FRTC_ADR_IRQ_EN, 32'h00000001);
    rc("irq enable", `FRTC_ADR_IRQ_EN, 16'h0001);
    check("irq", 16'(irq), 16'h0001);
    wr(`FRTC_ADR_IRQ_CLR, 32'h00000001);
    check("irq", 16'(irq), 16'h0000);
    rc("irq status", `FRTC_ADR_IRQ_STAT, 16'h0002);
    // Timer request follows enable and the CPU mask
    check("timer irq", 16'(timerIrq), 16'h0000);
    wr(`FRTC_ADR_CTRL1, 32'h00000080);
    repeat (2) @(posedge clk_sys);
    check("timer irq", 16'(timerIrq), 16'h0001);
    mask <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("timer irq", 16'(timerIrq), 16'h0000);
    mask <= 1'b0;
    // Two-step clear; the alternate low byte must not finish it
    rc("status", `FRTC_ADR_STATUS, 16'h0080);
    rd(`FRTC_ADR_ALT_LO, q);
    rc("status", `FRTC_ADR_STATUS, 16'h0080);
    rd(`FRTC_ADR_CNT_LO, q);
    rc("status", `FRTC_ADR_STATUS, 16'h0000);
    check("timer irq", 16'(timerIrq), 16'h0000);
    // Captured low byte survives counting; alternate write reloads too
    wr(`FRTC_ADR_ALT_LO, $urandom);
    rd(`FRTC_ADR_ALT_HI, q);
    halt <= 1'b0;
    repeat (48) @(posedge clk_sys);
    halt <= 1'b1;
    @(posedge clk_sys);
    rc("high", `FRTC_ADR_ALT_HI, 16'h0000);
    rc("held low", `FRTC_ADR_ALT_LO, 16'h00FC);
    rd(`FRTC_ADR_CNT_LO, q);
    check("live", 16'(q[7:0] >= 8'h01 && q[7:0] <= 8'h03), 16'h0001);
    // Pin counting, falling then rising polarity
    for (int e = 0; e < 2; e++) begin
      wr(`FRTC_ADR_CTRL2, 32'(3 + 4 * e));
      rc("ctrl2", `FRTC_ADR_CTRL2, 16'(3 + 4 * e));
      reload();
      halt <= 1'b0;
      k = $urandom_range(7, 1);
      repeat (k) begin
        pl = 1 - pl;
        if (pl == e) mc++;
      end
      i_frtc_ext_src.toggle(k);
      rdw(`FRTC_ADR_CNT_HI, w);
      check("pin count", w, 16'(mc));
    end
    // Edges while halted are lost; counting resumes from the held value
    halt <= 1'b1;
    i_frtc_ext_src.toggle(2);
    rdw(`FRTC_ADR_CNT_HI, w);
    check("halted", w, 16'(mc));
    halt <= 1'b0;
    i_frtc_ext_src.toggle(2);
    mc++;
    rdw(`FRTC_ADR_CNT_HI, w);
    check("resumed", w, 16'(mc));
    // Unbonded pin reads high: one rising step at most, then nothing
    if (pl == 0) mc++;
    bonded <= 1'b0;
    i_frtc_ext_src.toggle(3);
    rdw(`FRTC_ADR_CNT_HI, w);
    check("unbonded", w, 16'(mc));
    tally_and_finish();
  end

  // Watchdog, far beyond the several hundred cycles the tests need
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
